// ==== bench/event_src.sv ====
// partner: peripheral event sources, one flag event pulse at a time
// assumes the bench picks the source and fires just after a CLK_I edge
`timescale 1ns/1ps
module event_src
    import pirq_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       fire_i,
    input  wire logic [3:0] idx_i,
    output periph_events_t  ev_o
);
    periph_events_t ev_q = '0;
    // one-cycle pulse; idle sources sit low as real event logic does
    always_ff @(posedge clk_i) begin
        ev_q <= fire_i ? periph_events_t'(10'h1 << idx_i) : '0;
    end
    assign ev_o = ev_q;
endmodule

// ==== bench/tb.sv ====
// bench: wishbone register tests and event pulses for the flag block
// assumes one 25 MHz clock and a partner model for the event sources
`timescale 1ns/1ps
module tb;
    import pirq_pkg::*;
    logic           CLK_I, RESET_I, CYC_I, STB_I, WE_I, ACK_O, PERIPH_IRQ_O, GLOBAL_IRQ_ENABLE_O, fire, ce;
    logic [4:0]     ADR_I;
    logic [3:0]     SEL_I, idx;
    logic [31:0]    DAT_I, DAT_O, rdata;
    periph_events_t ev;
    int             err_count, checks_done;
    byte            ebit [10] = '{1, 3, 5, 4, 0, 3, 4, 5, 6, 7};
    event_src src (.clk_i(CLK_I), .fire_i(fire), .idx_i(idx), .ev_o(ev));
    periph_irq_flag_regs dut (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(ce), .CYC_I(CYC_I), .STB_I(STB_I),
        .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
        .EVENTS_I(ev), .PERIPH_IRQ_O(PERIPH_IRQ_O), .GLOBAL_IRQ_ENABLE_O(GLOBAL_IRQ_ENABLE_O));
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until ack is sampled, then one idle cycle
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= {24'h0, d};
        n = 0;
        do begin
            @(posedge CLK_I);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        rdata = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
        if (ACK_O !== 1'b1) begin
            err_count++;
            summarize();
        end
        @(posedge CLK_I);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rdata, {24'h0, exp});
    endtask
    task automatic rst();
        RESET_I <= 1'b1;
        repeat (12) @(posedge CLK_I);
        RESET_I <= 1'b0;
    endtask
    initial begin
        CLK_I = 1'b0;
        forever #20 CLK_I = ~CLK_I;
    end
    initial begin
        repeat (20000) @(posedge CLK_I);
        err_count++;
        summarize();
    end
    initial begin
        {CYC_I, STB_I, WE_I, fire, idx, ADR_I, DAT_I} = '0;
        RESET_I = 1'b1;
        ce = 1'b1;
        SEL_I = 4'h1;
        err_count = 0;
        checks_done = 0;
        // reset high from time zero so no flop is ever seen unknown
        repeat (12) @(posedge CLK_I);
        RESET_I <= 1'b0;
        for (int a = 0; a < 5; a++) rd(5'(a * 4), 8'h00);
        for (int i = 0; i < 10; i++) begin
            fire <= 1'b1;
            idx <= 4'(i);
            @(posedge CLK_I);
            fire <= 1'b0;
            repeat (2) @(posedge CLK_I);
            rd(5'h00, i > 3 ? 8'(1 << ebit[i]) : 8'h00);
            rd(5'h04, i < 4 ? 8'(1 << ebit[i]) : 8'h00);
            wr(i > 3 ? 5'h00 : 5'h04, 8'h00);
        end
        chk(PERIPH_IRQ_O, 0);
        wr(5'h00, 8'hff);
        rd(5'h00, 8'hf9);
        wr(5'h04, 8'hff);
        rd(5'h04, 8'h3a);
        wr(5'h0c, 8'hff);
        rd(5'h0c, 8'h3a);
        wr(5'h10, 8'h80);
        @(posedge CLK_I);
        chk(PERIPH_IRQ_O, 0);
        chk(GLOBAL_IRQ_ENABLE_O, 1);
        wr(5'h10, 8'h40);
        @(posedge CLK_I);
        chk(PERIPH_IRQ_O, 1);
        chk(GLOBAL_IRQ_ENABLE_O, 0);
        wr(5'h0c, 8'h02);
        @(posedge CLK_I);
        chk(PERIPH_IRQ_O, 1);
        wr(5'h04, 8'h38);
        @(posedge CLK_I);
        chk(PERIPH_IRQ_O, 0);
        wr(5'h14, 8'hff);
        rd(5'h14, 8'h00);
        rd(5'h10, 8'h40);
        wr(5'h08, 8'hff);
        rd(5'h08, 8'hf9);
        @(posedge CLK_I);
        chk(PERIPH_IRQ_O, 1);
        wr(5'h10, 8'h00);
        @(posedge CLK_I);
        chk(PERIPH_IRQ_O, 0);
        fire <= 1'b1;
        idx <= 4'h1;
        @(posedge CLK_I);
        fire <= 1'b0;
        wr(5'h04, 8'h00);
        rd(5'h04, 8'h08);
        rst();
        rd(5'h00, 8'h00);
        ce <= 1'b0;
        fire <= 1'b1;
        idx <= 4'h9;
        @(posedge CLK_I);
        fire <= 1'b0;
        repeat (2) @(posedge CLK_I);
        ce <= 1'b1;
        rd(5'h00, 8'h00);
        summarize();
    end
endmodule

// ==== core/periph_irq_flag_regs.sv ====
// peripheral interrupt flag and enable registers with a classic wishbone slave
// assumes event pulses come from logic on CLK_I; software owns enables and control
// Functional notes
// - events set flags regardless of any enable register bit, but only while CE_I is high
// - flags two: osc fail bit 7, comparator two bit 6, comparator one bit 5
// - flags two: nv write done bit 4, bus collision bit 3, capcomp two bit 0
// - unimplemented flag bits always read zero
// - flags three: capcomp four bit 5, capcomp three bit 4
// - flags three: timer six match bit 3, timer four match bit 1
// - flag reads one while pending, zero otherwise
// - all flags read/write, reset to zero on any reset
// - no peripheral request without peripheral enable bit
// - enables three mirror flag three positions; one enables
`timescale 1ns/1ps
`include "pirq_defines.svh"

module periph_irq_flag_regs
    import pirq_pkg::*;
(
    input  wire logic           CLK_I,
    input  wire logic           RESET_I,
    input  wire logic           CE_I,
    input  wire logic           CYC_I,
    input  wire logic           STB_I,
    input  wire logic           WE_I,
    input  wire logic [4:0]     ADR_I,
    input  wire logic [3:0]     SEL_I,
    input  wire logic [31:0]    DAT_I,
    output logic      [31:0]    DAT_O,
    output logic                ACK_O,
    input  wire periph_events_t EVENTS_I,
    output logic                PERIPH_IRQ_O,
    output logic                GLOBAL_IRQ_ENABLE_O
);
    logic [7:0] flags_two_q;
    logic [7:0] flags_three_q;
    logic [7:0] enables_two_q;
    logic [7:0] enables_three_q;
    logic [7:0] control_q;
    logic [7:0] ev_two;
    logic [7:0] ev_three;
    logic [7:0] rd_d;
    logic       req;
    logic       wr_two;
    logic       wr_three;
    logic       wr_en_two;
    logic       wr_en_three;
    logic       wr_ctrl;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        return (a[4:2] == off[4:2]);
    endfunction

    always_comb begin
        ev_two = 8'h00;
        ev_three = 8'h00;
        ev_two[`BIT_OSC_FAIL] = EVENTS_I.osc_fail;
        ev_two[`BIT_CMP_TWO] = EVENTS_I.comparator_two;
        ev_two[`BIT_CMP_ONE] = EVENTS_I.comparator_one;
        ev_two[`BIT_NV_DONE] = EVENTS_I.nv_write_done;
        ev_two[`BIT_BUS_COLL] = EVENTS_I.serial_bus_collision;
        ev_two[`BIT_CAPCOMP_TWO] = EVENTS_I.capcomp_two;
        ev_three[`BIT_CAPCOMP_FOUR] = EVENTS_I.capcomp_four;
        ev_three[`BIT_CAPCOMP_THREE] = EVENTS_I.capcomp_three;
        ev_three[`BIT_TIMER_SIX] = EVENTS_I.timer_six_match;
        ev_three[`BIT_TIMER_FOUR] = EVENTS_I.timer_four_match;
    end

    // single-cycle answer; ack drops the cycle after so a held strobe is not double counted
    assign req = CYC_I && STB_I && !ACK_O && CE_I;
    assign wr_two = req && WE_I && SEL_I[0] && hit(ADR_I, 5'(`ADR_FLAGS_TWO));
    assign wr_three = req && WE_I && SEL_I[0] && hit(ADR_I, 5'(`ADR_FLAGS_THREE));
    assign wr_en_two = req && WE_I && SEL_I[0] && hit(ADR_I, 5'(`ADR_ENABLES_TWO));
    assign wr_en_three = req && WE_I && SEL_I[0] && hit(ADR_I, 5'(`ADR_ENABLES_THREE));
    assign wr_ctrl = req && WE_I && SEL_I[0] && hit(ADR_I, 5'(`ADR_IRQ_CONTROL));

    // event set ORed after the write value so the event wins
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            flags_two_q <= `FLAGS_RESET;
        end else if (CE_I) begin
            flags_two_q <= ((wr_two ? DAT_I[7:0] : flags_two_q) | ev_two) & `MASK_TWO;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            flags_three_q <= `FLAGS_RESET;
        end else if (CE_I) begin
            flags_three_q <= ((wr_three ? DAT_I[7:0] : flags_three_q) | ev_three) & `MASK_THREE;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            enables_two_q <= `ENABLES_RESET;
            enables_three_q <= `ENABLES_RESET;
            control_q <= `CONTROL_RESET;
        end else if (CE_I) begin
            if (wr_en_two) begin
                enables_two_q <= DAT_I[7:0] & `MASK_TWO;
            end
            if (wr_en_three) begin
                enables_three_q <= DAT_I[7:0] & `MASK_THREE;
            end
            if (wr_ctrl) begin
                control_q <= DAT_I[7:0] & `MASK_CONTROL;
            end
        end
    end

    always_comb begin
        rd_d = 8'h00;
        if (hit(ADR_I, 5'(`ADR_FLAGS_TWO))) rd_d = flags_two_q;
        else if (hit(ADR_I, 5'(`ADR_FLAGS_THREE))) rd_d = flags_three_q;
        else if (hit(ADR_I, 5'(`ADR_ENABLES_TWO))) rd_d = enables_two_q;
        else if (hit(ADR_I, 5'(`ADR_ENABLES_THREE))) rd_d = enables_three_q;
        else if (hit(ADR_I, `ADR_IRQ_CONTROL)) rd_d = control_q;
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else if (CE_I) begin
            ACK_O <= req;
            if (req && !WE_I) begin
                DAT_O <= {24'h00_0000, rd_d};
            end
        end
    end

    // registered request; unmapped addresses ack with zero data
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            PERIPH_IRQ_O <= 1'b0;
        end else if (CE_I) begin
            PERIPH_IRQ_O <= control_q[`BIT_PERIPH_EN] &&
                            (|(flags_two_q & enables_two_q) || |(flags_three_q & enables_three_q));
        end
    end

    assign GLOBAL_IRQ_ENABLE_O = control_q[`BIT_GLOBAL_EN];

    a_req_gated: assert property (@(posedge CLK_I) disable iff (RESET_I)
        PERIPH_IRQ_O |-> $past(control_q[`BIT_PERIPH_EN]))
        else $error("request without peripheral enable");

    a_req_dropped: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && !control_q[`BIT_PERIPH_EN] |=> !PERIPH_IRQ_O)
        else $error("request stayed without peripheral enable");

    a_req_formed: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && control_q[`BIT_PERIPH_EN] && |(flags_three_q & enables_three_q) |=> PERIPH_IRQ_O)
        else $error("enabled pending flag gave no request");

    a_req_two: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && control_q[`BIT_PERIPH_EN] && |(flags_two_q & enables_two_q) |=> PERIPH_IRQ_O)
        else $error("enabled pending flag two gave no request");

    a_event_sets: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.osc_fail |=> flags_two_q[`BIT_OSC_FAIL])
        else $error("osc fail flag not set");

    a_event_cmp_two: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.comparator_two |=> flags_two_q[`BIT_CMP_TWO])
        else $error("comparator two flag not set");

    a_event_cmp_one: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.comparator_one |=> flags_two_q[`BIT_CMP_ONE])
        else $error("comparator one flag not set");

    a_event_nv_done: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.nv_write_done |=> flags_two_q[`BIT_NV_DONE])
        else $error("nv write done flag not set");

    a_event_collision: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.serial_bus_collision |=> flags_two_q[`BIT_BUS_COLL])
        else $error("bus collision flag not set");

    a_event_capcomp_two: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.capcomp_two |=> flags_two_q[`BIT_CAPCOMP_TWO])
        else $error("capcomp two flag not set");

    a_event_capcomp_four: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.capcomp_four |=> flags_three_q[`BIT_CAPCOMP_FOUR])
        else $error("capcomp four flag not set");

    a_event_capcomp_three: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.capcomp_three |=> flags_three_q[`BIT_CAPCOMP_THREE])
        else $error("capcomp three flag not set");

    a_event_timer_six: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.timer_six_match |=> flags_three_q[`BIT_TIMER_SIX])
        else $error("timer six flag not set");

    a_event_timer_four: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && EVENTS_I.timer_four_match |=> flags_three_q[`BIT_TIMER_FOUR])
        else $error("timer four flag not set");

    a_event_wins: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && wr_three && EVENTS_I.timer_six_match |=> flags_three_q[`BIT_TIMER_SIX])
        else $error("event lost to write");

    a_write_clear: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && wr_two && !DAT_I[4] && !EVENTS_I.nv_write_done |=> !flags_two_q[`BIT_NV_DONE])
        else $error("write zero did not clear");

    a_write_loads: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && wr_two && !(|ev_two) |=> flags_two_q == ($past(DAT_I[7:0]) & `MASK_TWO))
        else $error("write did not load flags two");

    a_unimpl_two: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (flags_two_q & ~`MASK_TWO) == 8'h00)
        else $error("unimplemented bits set");

    a_unimpl_three: assert property (@(posedge CLK_I) disable iff (RESET_I)
        (flags_three_q & ~`MASK_THREE) == 8'h00)
        else $error("unimplemented bits set");

    a_flag_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && req && !WE_I && hit(ADR_I, 5'(`ADR_FLAGS_THREE)) |=> DAT_O[7:0] == $past(flags_three_q))
        else $error("flag read mismatch");

    a_read_two: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && req && !WE_I && hit(ADR_I, 5'(`ADR_FLAGS_TWO)) |=> DAT_O[7:0] == $past(flags_two_q))
        else $error("flag two read mismatch");

    a_reset_zero: assert property (@(posedge CLK_I)
        $past(RESET_I) |-> flags_two_q == 8'h00 && flags_three_q == 8'h00)
        else $error("flags not reset");

    a_enable_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && wr_en_three |=> enables_three_q == ($past(DAT_I[7:0]) & `MASK_THREE))
        else $error("enables three write mismatch");

    a_ack_once: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && ACK_O |=> !ACK_O)
        else $error("ack held two cycles");

    a_ack_follows: assert property (@(posedge CLK_I) disable iff (RESET_I)
        CE_I && req |=> ACK_O)
        else $error("taken request not acknowledged");

    // a low enable must hold every flag, events included
    a_freeze_flags: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !CE_I |=> flags_two_q == $past(flags_two_q) && flags_three_q == $past(flags_three_q))
        else $error("flags moved while frozen");
endmodule

// ==== core/pirq_defines.svh ====
// register offsets, field positions and reset values for the peripheral flag block
// included by the design only; definitions only
`ifndef PIRQ_DEFINES_SVH
`define PIRQ_DEFINES_SVH
`define ADR_FLAGS_TWO     5'h00
`define ADR_FLAGS_THREE   5'h04
`define ADR_ENABLES_TWO   5'h08
`define ADR_ENABLES_THREE 5'h0c
`define ADR_IRQ_CONTROL   5'h10
`define FLAGS_RESET       8'h00
`define ENABLES_RESET     8'h00
`define CONTROL_RESET     8'h00
`define MASK_CONTROL      8'hc0
`define MASK_TWO          8'hf9
`define MASK_THREE        8'h3a
`define BIT_OSC_FAIL      7
`define BIT_CMP_TWO       6
`define BIT_CMP_ONE       5
`define BIT_NV_DONE       4
`define BIT_BUS_COLL      3
`define BIT_CAPCOMP_TWO   0
`define BIT_CAPCOMP_FOUR  5
`define BIT_CAPCOMP_THREE 4
`define BIT_TIMER_SIX     3
`define BIT_TIMER_FOUR    1
`define BIT_GLOBAL_EN     7
`define BIT_PERIPH_EN     6
`endif

// ==== core/pirq_pkg.sv ====
// types shared by the peripheral flag block
// assumes pirq_defines.svh is on the include path
package pirq_pkg;
    typedef struct packed {
        logic osc_fail;
        logic comparator_two;
        logic comparator_one;
        logic nv_write_done;
        logic serial_bus_collision;
        logic capcomp_two;
        logic capcomp_three;
        logic capcomp_four;
        logic timer_six_match;
        logic timer_four_match;
    } periph_events_t;
endpackage
